// file: dpio_pkg.sv
// Package with offsets, reset values, access states and strobe decode for the dual I/O port
package dpio_pkg;

  localparam int unsigned DPIO_W        = 8;
  localparam int unsigned DPIO_TERMS    = 24;
  localparam int unsigned DPIO_WIDE_CS  = 4;
  localparam int unsigned DPIO_WIDE_PT  = 4;
  localparam int unsigned DPIO_NARR_PT  = 2;

  localparam logic [2:0] OFS_PA_PIN = 3'h2;
  localparam logic [2:0] OFS_PB_PIN = 3'h3;
  localparam logic [2:0] OFS_PA_DIR = 3'h4;
  localparam logic [2:0] OFS_PB_DIR = 3'h5;
  localparam logic [2:0] OFS_PA_DAT = 3'h6;
  localparam logic [2:0] OFS_PB_DAT = 3'h7;

  localparam logic [7:0] RST_DIR    = 8'h00;
  localparam logic [7:0] RST_DAT    = 8'h00;
  localparam logic [7:0] RST_SAMPLE = 8'h00;
  localparam logic [7:0] ALL_DRIVE  = 8'h00;
  localparam logic [7:0] ALL_FLOAT  = 8'hFF;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_WR   = 2'b01,
    ACC_RD   = 2'b10
  } dpio_acc_e;

  // Write cycle: style 0 uses write strobe low, style 1 uses E high with R/W low
  function automatic logic dpio_wr_act(input logic style, input logic wr_rw, input logic rd_e);
    dpio_wr_act = style ? (rd_e & ~wr_rw) : ~wr_rw;
  endfunction

  // Read cycle: style 0 uses read strobe low, style 1 uses E high with R/W high
  function automatic logic dpio_rd_act(input logic style, input logic wr_rw, input logic rd_e);
    dpio_rd_act = style ? (rd_e & wr_rw) : ~rd_e;
  endfunction

endpackage

// file: dpio_pt_if.sv
// Interface carrying decoder product terms and the formed chip-select outputs
`timescale 1ns/1ps
`default_nettype none
interface dpio_pt_if;
  import dpio_pkg::*;
  logic [DPIO_TERMS-1:0] terms;
  logic [DPIO_W-1:0]     cs;
  modport src (output terms, input cs);
  modport frm (input terms, output cs);
endinterface
`default_nettype wire

// file: dpio_cs_form.sv
// Forms the eight decoder select outputs from their product terms
`timescale 1ns/1ps
`default_nettype none
module dpio_cs_form
  import dpio_pkg::*;
(
  dpio_pt_if.frm pt
);

  genvar n;
  generate
    for (n = 0; n < DPIO_WIDE_CS; n++) begin : g_wide
      assign pt.cs[n] = |pt.terms[n*DPIO_WIDE_PT +: DPIO_WIDE_PT];
    end
    for (n = DPIO_WIDE_CS; n < DPIO_W; n++) begin : g_narrow
      assign pt.cs[n] = |pt.terms[DPIO_WIDE_CS*DPIO_WIDE_PT + (n-DPIO_WIDE_CS)*DPIO_NARR_PT
                                  +: DPIO_NARR_PT];
    end
  endgenerate

endmodule
`default_nettype wire

// file: dpio_top.sv
// Dual 8-bit I/O port with general I/O, latched address, track, chip-select and data-bus roles
`timescale 1ns/1ps
`default_nettype none
module dpio_top
  import dpio_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic [DPIO_W-1:0]     ad_i,
  output logic      [DPIO_W-1:0]     ad_o,
  output logic      [DPIO_W-1:0]     ad_oe_n_o,
  input  wire logic                  address_latch_strobe_i,
  input  wire logic                  wr_rw_i,
  input  wire logic                  read_strobe_i,
  input  wire logic                  byte_high_enable_n_i,
  input  wire logic                  port_register_space_i,
  input  wire logic                  track_read_in_select_i,
  input  wire logic                  track_address_out_select_i,
  input  wire logic                  track_write_out_select_i,
  input  wire logic [DPIO_TERMS-1:0] product_terms_i,
  input  wire logic                  strobe_style_bit_i,
  input  wire logic                  nonmux_mode_i,
  input  wire logic                  bus16_mode_i,
  input  wire logic                  pa_track_mode_i,
  input  wire logic [DPIO_W-1:0]     pa_latched_addr_sel_i,
  input  wire logic [DPIO_W-1:0]     pb_decoder_sel_i,
  input  wire logic [DPIO_W-1:0]     pa_driver_type_select_i,
  input  wire logic [DPIO_W-1:0]     pb_driver_type_select_i,
  input  wire logic [DPIO_W-1:0]     first_port_pins_i,
  output logic      [DPIO_W-1:0]     first_port_pins_o,
  output logic      [DPIO_W-1:0]     first_port_pins_oe_n_o,
  input  wire logic [DPIO_W-1:0]     second_port_pins_i,
  output logic      [DPIO_W-1:0]     second_port_pins_o,
  output logic      [DPIO_W-1:0]     second_port_pins_oe_n_o
);

  logic [DPIO_W-1:0] pa_direction_flop;
  logic [DPIO_W-1:0] pa_dat_ff;
  logic [DPIO_W-1:0] pb_direction_flop;
  logic [DPIO_W-1:0] pb_dat_ff;
  logic [DPIO_W-1:0] ad_ff;
  logic              ale_ff;
  logic [DPIO_W-1:0] addr_lat_ff;
  dpio_acc_e         acc_st_ff;
  logic [2:0]        acc_addr_ff;
  logic              wide_ff;
  logic [DPIO_W-1:0] wlo_ff;
  logic [DPIO_W-1:0] whi_ff;
  logic [DPIO_W-1:0] pa_o_ff;
  logic [DPIO_W-1:0] pa_oe_n_ff;
  logic [DPIO_W-1:0] pb_o_ff;
  logic [DPIO_W-1:0] pb_oe_n_ff;
  logic [DPIO_W-1:0] ad_o_ff;
  logic [DPIO_W-1:0] ad_oe_n_ff;
  logic [DPIO_W-1:0] nxt_pa_o;
  logic [DPIO_W-1:0] nxt_pa_oe_n;
  logic [DPIO_W-1:0] nxt_pb_o;
  logic [DPIO_W-1:0] nxt_pb_oe_n;
  logic [DPIO_W-1:0] nxt_ad_o;
  logic [DPIO_W-1:0] nxt_ad_oe_n;
  logic              wr_act;
  logic              rd_act;
  logic              rd_on;
  logic              commit;
  logic [2:0]        req_addr;
  logic              req_wide;
  logic [DPIO_W-1:0] rlo;
  logic [DPIO_W-1:0] rhi;

  dpio_pt_if pt_bus ();
  assign pt_bus.terms = product_terms_i;
  dpio_cs_form u_cs_form (
    .pt (pt_bus.frm)
  );

  // Register byte as seen by a host read; pin-sample bytes show live pin levels
  function automatic logic [DPIO_W-1:0] reg_byte(input logic [2:0] a);
    case (a)
      OFS_PA_PIN: reg_byte = first_port_pins_i;
      OFS_PB_PIN: reg_byte = second_port_pins_i;
      OFS_PA_DIR: reg_byte = pa_direction_flop;
      OFS_PB_DIR: reg_byte = pb_direction_flop;
      OFS_PA_DAT: reg_byte = pa_dat_ff;
      OFS_PB_DAT: reg_byte = pb_dat_ff;
      default:    reg_byte = RST_SAMPLE;
    endcase
  endfunction

  assign wr_act   = dpio_wr_act(strobe_style_bit_i, wr_rw_i, read_strobe_i);
  assign rd_act   = dpio_rd_act(strobe_style_bit_i, wr_rw_i, read_strobe_i);
  assign rd_on    = (acc_st_ff == ACC_RD) && rd_act;
  assign commit   = (acc_st_ff == ACC_WR) && !wr_act;
  // Non-multiplexed hosts present the address directly on the address pins
  assign req_addr = nonmux_mode_i ? ad_i[2:0] : addr_lat_ff[2:0];
  // Paired access needs 16-bit mode, byte-high-enable low and an even offset
  assign req_wide = bus16_mode_i && !byte_high_enable_n_i && !req_addr[0];
  // Procedural so later register and pin changes reach the read bytes
  always_comb begin
    rlo = reg_byte(acc_addr_ff);
    rhi = reg_byte(acc_addr_ff | 3'h1);
  end

  // Address/data pins and strobe sampled for trailing-edge detection
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ad_ff  <= RST_DAT;
      ale_ff <= 1'b0;
    end else begin
      ad_ff  <= ad_i;
      ale_ff <= address_latch_strobe_i;
    end
  end

  // Low-order address latch, bit n feeds Port A pin n
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_lat_ff <= RST_DAT;
    end else if (ale_ff && !address_latch_strobe_i) begin
      addr_lat_ff <= ad_ff;
    end
  end

  // Host access sequencer
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_st_ff   <= ACC_IDLE;
      acc_addr_ff <= 3'h0;
      wide_ff     <= 1'b0;
    end else begin
      case (acc_st_ff)
        ACC_IDLE: begin
          if (port_register_space_i && (wr_act || rd_act)) begin
            acc_st_ff   <= wr_act ? ACC_WR : ACC_RD;
            acc_addr_ff <= req_addr;
            wide_ff     <= req_wide;
          end
        end
        ACC_WR: begin
          if (!wr_act) begin
            acc_st_ff <= ACC_IDLE;
          end
        end
        ACC_RD: begin
          if (!rd_act) begin
            acc_st_ff <= ACC_IDLE;
          end
        end
        default: acc_st_ff <= ACC_IDLE;
      endcase
    end
  end

  // Write data follows the bus while the strobe is active
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wlo_ff <= RST_DAT;
      whi_ff <= RST_DAT;
    end else if (wr_act) begin
      wlo_ff <= nonmux_mode_i ? first_port_pins_i : ad_i;
      whi_ff <= second_port_pins_i;
    end
  end

  // Direction and output-data registers, committed at end of write strobe
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pa_direction_flop <= RST_DIR;
      pb_direction_flop <= RST_DIR;
      pa_dat_ff <= RST_DAT;
      pb_dat_ff <= RST_DAT;
    end else if (commit) begin
      case (acc_addr_ff)
        OFS_PA_DIR: begin
          pa_direction_flop <= wlo_ff;
          if (wide_ff) begin
            pb_direction_flop <= whi_ff;
          end
        end
        OFS_PB_DIR: pb_direction_flop <= wlo_ff;
        OFS_PA_DAT: begin
          pa_dat_ff <= wlo_ff;
          if (wide_ff) begin
            pb_dat_ff <= whi_ff;
          end
        end
        OFS_PB_DAT: pb_dat_ff <= wlo_ff;
        default: begin
        end
      endcase
    end
  end

  // Pin drive selection; configuration inputs are static
  always_comb begin
    logic drv;
    logic val;
    drv         = 1'b0;
    val         = 1'b0;
    nxt_pa_o    = RST_DAT;
    nxt_pa_oe_n = ALL_FLOAT;
    nxt_pb_o    = RST_DAT;
    nxt_pb_oe_n = ALL_FLOAT;
    nxt_ad_o    = RST_DAT;
    nxt_ad_oe_n = ALL_FLOAT;
    for (int i = 0; i < DPIO_W; i++) begin
      if (pa_track_mode_i) begin
        drv = (track_address_out_select_i && address_latch_strobe_i)
           || (track_write_out_select_i && wr_act);
        nxt_pa_o[i]    = ad_i[i];
        nxt_pa_oe_n[i] = !drv;
      end else begin
        if (nonmux_mode_i) begin
          drv = rd_on;
          val = rlo[i];
        end else if (pa_latched_addr_sel_i[i]) begin
          drv = 1'b1;
          val = addr_lat_ff[i];
        end else begin
          drv = pa_direction_flop[i];
          val = pa_dat_ff[i];
        end
        // Open-drain releases the pin for a high level
        nxt_pa_o[i]    = pa_driver_type_select_i[i] ? 1'b0 : val;
        nxt_pa_oe_n[i] = !(drv && !(pa_driver_type_select_i[i] && val));
      end
      if (bus16_mode_i && rd_on && wide_ff) begin
        drv = 1'b1;
        val = rhi[i];
      end else if (pb_decoder_sel_i[i]) begin
        drv = 1'b1;
        val = pt_bus.cs[i];
      end else begin
        drv = pb_direction_flop[i];
        val = pb_dat_ff[i];
      end
      nxt_pb_o[i]    = pb_driver_type_select_i[i] ? 1'b0 : val;
      nxt_pb_oe_n[i] = !(drv && !(pb_driver_type_select_i[i] && val));
    end
    if (pa_track_mode_i && track_read_in_select_i && rd_act) begin
      nxt_ad_o    = first_port_pins_i;
      nxt_ad_oe_n = ALL_DRIVE;
    end else if (!nonmux_mode_i && rd_on) begin
      nxt_ad_o    = rlo;
      nxt_ad_oe_n = ALL_DRIVE;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pa_o_ff    <= RST_DAT;
      pa_oe_n_ff <= ALL_FLOAT;
      pb_o_ff    <= RST_DAT;
      pb_oe_n_ff <= ALL_FLOAT;
      ad_o_ff    <= RST_DAT;
      ad_oe_n_ff <= ALL_FLOAT;
    end else begin
      pa_o_ff    <= nxt_pa_o;
      pa_oe_n_ff <= nxt_pa_oe_n;
      pb_o_ff    <= nxt_pb_o;
      pb_oe_n_ff <= nxt_pb_oe_n;
      ad_o_ff    <= nxt_ad_o;
      ad_oe_n_ff <= nxt_ad_oe_n;
    end
  end

  assign first_port_pins_o       = pa_o_ff;
  assign first_port_pins_oe_n_o  = pa_oe_n_ff;
  assign second_port_pins_o      = pb_o_ff;
  assign second_port_pins_oe_n_o = pb_oe_n_ff;
  assign ad_o                    = ad_o_ff;
  assign ad_oe_n_o               = ad_oe_n_ff;

  a_gpio_input_float: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (!pa_track_mode_i && !nonmux_mode_i && !pa_latched_addr_sel_i[0] && !pa_direction_flop[0])
      |=> first_port_pins_oe_n_o[0])
    else $error("Input pin is driven");

  a_gpio_output_data: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (!pa_track_mode_i && !nonmux_mode_i && !pa_latched_addr_sel_i[0]
      && !pa_driver_type_select_i[0] && pa_direction_flop[0])
      |=> (!first_port_pins_oe_n_o[0] && first_port_pins_o[0] == $past(pa_dat_ff[0])))
    else $error("Output pin does not show data bit");

  a_pin_sample_read: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (rd_on && acc_addr_ff == OFS_PA_PIN && !pa_track_mode_i && !nonmux_mode_i)
      |=> (ad_oe_n_o == ALL_DRIVE && ad_o == $past(first_port_pins_i)))
    else $error("Pin-sample read differs from pin level");

  a_open_drain_high: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (!pb_decoder_sel_i[0] && !bus16_mode_i && pb_driver_type_select_i[0]
      && pb_direction_flop[0] && pb_dat_ff[0])
      |=> second_port_pins_oe_n_o[0])
    else $error("Open-drain pin driven high");

  a_addr_latch_edge: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (ale_ff && !address_latch_strobe_i) |=> (addr_lat_ff == $past(ad_ff)))
    else $error("Address not latched at strobe end");

  a_track_addr_out: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (pa_track_mode_i && track_address_out_select_i && address_latch_strobe_i)
      |=> (first_port_pins_oe_n_o == ALL_DRIVE && first_port_pins_o == $past(ad_i)))
    else $error("Track address not passed to Port A");

  a_track_write_out: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (pa_track_mode_i && track_write_out_select_i && wr_act)
      |=> (first_port_pins_oe_n_o == ALL_DRIVE && first_port_pins_o == $past(ad_i)))
    else $error("Track write data not passed to Port A");

  a_track_read_in: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (pa_track_mode_i && track_read_in_select_i && rd_act)
      |=> (ad_oe_n_o == ALL_DRIVE && ad_o == $past(first_port_pins_i)))
    else $error("Track read data not passed to bus");

  a_track_float_idle: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (pa_track_mode_i && !(track_address_out_select_i && address_latch_strobe_i)
      && !(track_write_out_select_i && wr_act))
      |=> first_port_pins_oe_n_o == ALL_FLOAT)
    else $error("Track port driven while idle");

  a_select_route: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (pb_decoder_sel_i[0] && !bus16_mode_i && !pb_driver_type_select_i[0])
      |=> (!second_port_pins_oe_n_o[0]
           && second_port_pins_o[0] == $past(|product_terms_i[3:0])))
    else $error("Select 0 not routed to Port B pin 0");

  a_wide_read_high: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (bus16_mode_i && rd_on && wide_ff && acc_addr_ff == OFS_PA_DIR
      && pb_driver_type_select_i == 8'h00)
      |=> (second_port_pins_oe_n_o == ALL_DRIVE && second_port_pins_o == $past(pb_direction_flop)))
    else $error("Wide read high byte not on Port B");

endmodule
`default_nettype wire

// file: dpio_host_model.sv
// Host bus model driving strobes and the low address/data pins
`timescale 1ns/1ps
`default_nettype none
module dpio_host_model
  import dpio_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic [DPIO_W-1:0] ad_out_i,
  input  wire logic [DPIO_W-1:0] ad_oe_n_i,
  output logic      [DPIO_W-1:0] ad_pin_o,
  output logic                   ale_o,
  output logic                   wr_o,
  output logic                   rd_o,
  output logic                   sel_o,
  output logic                   bhe_n_o
);
  logic [DPIO_W-1:0] h_ad = 8'h00;
  logic              h_en = 1'b0;
  // Released lines show the host value while h_en is set, otherwise the inverse of the last host value
  assign ad_pin_o = (ad_out_i & ~ad_oe_n_i) | ((h_en ? h_ad : ~h_ad) & ad_oe_n_i);
  assign bhe_n_o  = 1'b0;
  initial begin
    ale_o = 1'b0;
    wr_o  = 1'b1;
    rd_o  = 1'b1;
    sel_o = 1'b0;
  end
  task automatic cyc(input logic a, input logic w, input logic r, input logic s,
                     input logic e, input logic [7:0] d, input int n);
    @(posedge ref_clk_i);
    ale_o <= a;
    wr_o  <= w;
    rd_o  <= r;
    sel_o <= s;
    h_en  <= e;
    h_ad  <= d;
    repeat (n - 1) @(posedge ref_clk_i);
  endtask
  // Select held over the whole strobe
  task automatic acc(input logic [2:0] ofs, input logic w, input logic [7:0] d,
                     output logic [7:0] q);
    cyc(1, 1, 1, 0, 1, {5'h00, ofs}, 1);
    cyc(0, 1, 1, 0, 1, {5'h00, ofs}, 1);
    q = 8'h00;
    if (w) begin
      cyc(0, 0, 1, 1, 1, d, 2);
    end else begin
      cyc(0, 1, 0, 1, 0, d, 2);
      for (int i = 0; i < 8; i++) begin
        @(negedge ref_clk_i);
        if (ad_oe_n_i === 8'h00) break;
      end
      q = ad_out_i;
    end
    cyc(0, 1, 1, 0, 0, 8'h00, 3);
  endtask
endmodule
`default_nettype wire

// file: tb_dpio_top.sv
// Testbench for the dual I/O port with a host bus model
`timescale 1ns/1ps
`default_nettype none
module tb_dpio_top;
  import dpio_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic [7:0]  ad_i, ad_o, ad_oe_n, pa_o, pa_oe_n, pb_o, pb_oe_n, pa_i, pb_i, q;
  logic [7:0]  ext_a = 8'hFF, ext_b = 8'hFF, pa_la = 8'h00, pb_cs = 8'h00;
  logic [7:0]  pa_od = 8'h00, pb_od = 8'h00;
  logic [23:0] terms = 24'h0;
  logic        ale, wr, rd, sel, bhe_n;
  logic        t_rd = 1'b0, t_ad = 1'b0, t_wr = 1'b0, style = 1'b0;
  logic        nm = 1'b0, b16 = 1'b0, trk = 1'b0;
  int          errors = 0;
  int          total_checks = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  // Released pins read the board pull-up or external source
  assign pa_i = (pa_o & ~pa_oe_n) | (ext_a & pa_oe_n);
  assign pb_i = (pb_o & ~pb_oe_n) | (ext_b & pb_oe_n);
  dpio_host_model host_u (.ref_clk_i(ref_clk_i), .ad_out_i(ad_o), .ad_oe_n_i(ad_oe_n),
    .ad_pin_o(ad_i), .ale_o(ale), .wr_o(wr), .rd_o(rd), .sel_o(sel), .bhe_n_o(bhe_n));
  dpio_top dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ad_i(ad_i), .ad_o(ad_o),
    .ad_oe_n_o(ad_oe_n), .address_latch_strobe_i(ale), .wr_rw_i(wr), .read_strobe_i(rd),
    .byte_high_enable_n_i(bhe_n), .port_register_space_i(sel),
    .track_read_in_select_i(t_rd), .track_address_out_select_i(t_ad),
    .track_write_out_select_i(t_wr), .product_terms_i(terms), .strobe_style_bit_i(style),
    .nonmux_mode_i(nm), .bus16_mode_i(b16), .pa_track_mode_i(trk),
    .pa_latched_addr_sel_i(pa_la), .pb_decoder_sel_i(pb_cs),
    .pa_driver_type_select_i(pa_od), .pb_driver_type_select_i(pb_od),
    .first_port_pins_i(pa_i), .first_port_pins_o(pa_o), .first_port_pins_oe_n_o(pa_oe_n),
    .second_port_pins_i(pb_i), .second_port_pins_o(pb_o),
    .second_port_pins_oe_n_o(pb_oe_n));
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rdc(input logic [2:0] ofs, input logic [7:0] exp, input string name);
    host_u.acc(ofs, 1'b0, 8'h00, q);
    chk(name, q, exp);
  endtask
  task automatic wr_reg(input logic [2:0] ofs, input logic [7:0] d);
    host_u.acc(ofs, 1'b1, d, q);
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask
  initial begin
    #200000;
    errors++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    w(1);
    chk("pa_oe_n", pa_oe_n, ALL_FLOAT);
    chk("pb_oe_n", pb_oe_n, ALL_FLOAT);
    rdc(OFS_PA_DIR, RST_DIR, "pa_dir");
    rdc(OFS_PB_DIR, RST_DIR, "pb_dir");
    rdc(OFS_PA_DAT, RST_DAT, "pa_dat");
    rdc(OFS_PB_DAT, RST_DAT, "pb_dat");
    @(posedge ref_clk_i) nm <= 1'b1;
    ext_a <= 8'h99;
    host_u.cyc(0, 0, 1, 1, 1, 8'h06, 2);
    host_u.cyc(0, 1, 1, 0, 0, 8'h06, 3);
    // Non-multiplexed read drives Port A, not the address/data pins
    host_u.cyc(0, 1, 0, 1, 1, 8'h06, 3);
    @(negedge ref_clk_i);
    chk("pa nonmux rd", pa_o, 8'h99);
    chk("pa nonmux rd oe", pa_oe_n, ALL_DRIVE);
    chk("ad nonmux rd oe", ad_oe_n, ALL_FLOAT);
    host_u.cyc(0, 1, 1, 0, 0, 8'h06, 3);
    nm <= 1'b0;
    rdc(OFS_PA_DAT, 8'h99, "pa_dat nonmux");
    b16 <= 1'b1;
    ext_b <= 8'h22;
    wr_reg(OFS_PA_DIR, 8'h11);
    rdc(OFS_PA_DIR, 8'h11, "pa_dir wide");
    rdc(OFS_PB_DIR, 8'h22, "pb_dir wide");
    b16 <= 1'b0;
    ext_a <= 8'h3C;
    ext_b <= 8'hFF;
    wr_reg(OFS_PA_DIR, 8'hF0);
    wr_reg(OFS_PA_DAT, 8'hA5);
    w(2);
    chk("pa_oe_n", pa_oe_n, 8'h0F);
    chk("pa_out", pa_o & 8'hF0, 8'hA0);
    rdc(OFS_PA_PIN, 8'hAC, "pa_pin");
    wr_reg(OFS_PA_PIN, 8'h00);
    rdc(OFS_PA_PIN, 8'hAC, "pa_pin ro");
    rdc(3'h0, 8'h00, "unmapped");
    @(posedge ref_clk_i) pb_od <= 8'h0F;
    wr_reg(OFS_PB_DIR, 8'hFF);
    wr_reg(OFS_PB_DAT, 8'h5A);
    w(2);
    chk("pb_oe_n", pb_oe_n, 8'h0A);
    chk("pb_out", pb_o & 8'hF0, 8'h50);
    rdc(OFS_PB_PIN, 8'h5A, "pb_pin");
    @(posedge ref_clk_i) pa_la <= 8'hFF;
    host_u.cyc(1, 1, 1, 0, 1, 8'hC5, 2);
    host_u.cyc(0, 1, 1, 0, 1, 8'h3C, 3);
    @(negedge ref_clk_i);
    chk("pa_addr", pa_o, 8'hC5);
    chk("pa_addr oe", pa_oe_n, ALL_DRIVE);
    @(posedge ref_clk_i) pa_la <= 8'h00;
    trk <= 1'b1;
    t_ad <= 1'b1;
    host_u.cyc(1, 1, 1, 0, 1, 8'h96, 3);
    @(negedge ref_clk_i);
    chk("trk addr", pa_o, 8'h96);
    chk("trk addr oe", pa_oe_n, ALL_DRIVE);
    host_u.cyc(0, 1, 1, 0, 1, 8'h96, 1);
    t_ad <= 1'b0;
    t_wr <= 1'b1;
    w(2);
    chk("trk idle", pa_oe_n, ALL_FLOAT);
    host_u.cyc(0, 0, 1, 0, 1, 8'h3E, 3);
    @(negedge ref_clk_i);
    chk("trk wr", pa_o, 8'h3E);
    @(posedge ref_clk_i) style <= 1'b1;
    host_u.cyc(0, 0, 1, 0, 1, 8'h5C, 3);
    @(negedge ref_clk_i);
    chk("trk wr e", pa_o, 8'h5C);
    host_u.cyc(0, 0, 0, 0, 1, 8'h5C, 3);
    @(negedge ref_clk_i);
    chk("trk e low", pa_oe_n, ALL_FLOAT);
    @(posedge ref_clk_i) style <= 1'b0;
    t_wr <= 1'b0;
    t_rd <= 1'b1;
    ext_a <= 8'h71;
    host_u.cyc(0, 1, 0, 0, 0, 8'h00, 3);
    @(negedge ref_clk_i);
    chk("trk rd", ad_o, 8'h71);
    chk("trk rd oe", ad_oe_n, ALL_DRIVE);
    @(posedge ref_clk_i) trk <= 1'b0;
    t_rd <= 1'b0;
    host_u.cyc(0, 1, 1, 0, 0, 8'h00, 2);
    @(posedge ref_clk_i) pb_cs <= 8'hFF;
    pb_od <= 8'h00;
    for (int n = 0; n < 8; n++) begin
      @(posedge ref_clk_i) terms <= (n < 4) ? 24'h1 << (4 * n + 3) : 24'h1 << (2 * n + 9);
      w(2);
      chk("cs", pb_o, 8'h01 << n);
      chk("cs oe", pb_oe_n, ALL_DRIVE);
    end
    stop_test();
  end
endmodule
`default_nettype wire
